/* File: oaa_unit.sv */
// Operand and address attribute unit with its register slave
//
// How it works
// RL1: Offset register advances or reloads on transfers
// RL2: Software has no direct path to offset
// RL3: Call pushes offset; returns reload from stack
// RL4: Prefetch addresses never disturb architectural offset
// RL5: Protected mode default size from flag
// RL6: Real, v86, management modes force 16
// RL7: Operand widths 8/16 or 8/32
// RL8: 16-bit address uses 16-bit offsets
// RL9: 32-bit address uses 32-bit offsets
// RL10: Prefixes affect only their own instruction
// RL11: 66H/67H prefixes toggle default sizes
// RL12: Destination is never an immediate
// RL13: Divide refuses immediates; immediate fits doubleword
// RL14: Pair high half data, low accumulator
// RL15: Stack ops and SP/BP base use stack
// RL16: Fetch code, string destination extra, else data
// RL17: Segment override prefix replaces data segment
// RL18: Overrides ignored for fetch, strings, stack
// RL19: Explicit selector is sixteen bits wide
// RL20: Far pointer: offset dword, then selector
// RL21: Address sums displacement, base, scaled index
// RL22: Components signed, scale always positive
// RL23: Stack pointer never serves as index
// RL24: Scale only with index; components optional
// RL25: Address wraps to address size
//
// Our own choices: the address map and the AHB-Lite slave port.
`include "oaa_defines.svh"
module oaa_unit
	import oaa_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input oaa_dec_t dec,
	input wire logic [31:0] ret_ptr,
	output oaa_res_t res,
	output logic [31:0] next_instr_offset
);

	function automatic logic [31:0] mask_size(input logic wide, input logic [31:0] v);
		mask_size = wide ? v : (v & `OAA_MASK16);
	endfunction : mask_size

	////////////////////////////////////////////////////////////////////////
	// Register slave

	logic [31:0] ctrl_r;
	logic [31:0] hrdata_r;
	logic wr_pend_r;
	logic [7:0] wr_ofs_r;
	logic [31:0] ctrl_nxt;
	logic [31:0] rd_nxt;
	oaa_res_t res_r;
	oaa_res_t res_nxt;
	logic [31:0] ip_r;
	logic [31:0] ip_nxt;
	logic hreadyout_r;
	logic hresp_r;

	wire logic addr_phase;
	wire logic [7:0] ofs;
	wire logic [31:0] stat_word;

	assign addr_phase = hsel && hready && (htrans == `OAA_HTRANS_NONSEQ);
	assign ofs = haddr[7:0];
	assign stat_word = {24'h00_0000, 1'b0, res_r.seg, 1'b0, res_r.fault, res_r.ad32,
		res_r.op32};

	// Unmapped offsets read as zero; the offset register has no address
	always_comb begin // RL2
		case (ofs)
			`OAA_CTRL_OFS: rd_nxt = ctrl_r;
			`OAA_STAT_OFS: rd_nxt = stat_word;
			`OAA_EA_OFS: rd_nxt = res_r.ea;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	assign ctrl_nxt = (wr_pend_r && wr_ofs_r == `OAA_CTRL_OFS) ? {28'h000_0000, hwdata[3:0]}
		: ctrl_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= `OAA_CTRL_RST;
			hrdata_r <= 32'h0000_0000;
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			wr_pend_r <= addr_phase && hwrite;
			wr_ofs_r <= ofs;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			if (addr_phase && !hwrite) begin
				hrdata_r <= rd_nxt;
			end
		end
	end

	// Zero wait states, always OKAY; held in flops like every other output
	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;

	////////////////////////////////////////////////////////////////////////
	// Size attributes

	wire logic prot;
	wire logic def32;
	wire logic op32;
	wire logic ad32;

	// Virtual-8086 and management mode override protection
	assign prot = ctrl_r[`OAA_CTRL_PROT] && !ctrl_r[`OAA_CTRL_V86]
		&& !ctrl_r[`OAA_CTRL_SMM]; // RL6
	assign def32 = prot && ctrl_r[`OAA_CTRL_DFLAG]; // RL5 RL6
	// Prefixes come with each decode word and are never latched
	assign op32 = def32 ^ dec.pfx_op; // RL10 RL11
	assign ad32 = def32 ^ dec.pfx_ad; // RL10 RL11

	////////////////////////////////////////////////////////////////////////
	// Segment choice

	wire logic stack_base;
	oaa_seg_t data_seg;
	oaa_seg_t seg_sel;

	assign stack_base = dec.base_en && (dec.base_idx == `OAA_REG_SP
		|| dec.base_idx == `OAA_REG_BP); // RL15
	assign data_seg = dec.seg_ovr ? dec.ovr_seg
		: (stack_base ? SEG_SS : SEG_DS); // RL15 RL16 RL17

	// Fixed kinds ignore any override prefix
	always_comb begin
		case (dec.ref_kind)
			REF_FETCH: seg_sel = SEG_CS; // RL16 RL18
			REF_STACK: seg_sel = SEG_SS; // RL15 RL18
			REF_STRDST: seg_sel = SEG_ES; // RL16 RL18
			default: seg_sel = data_seg; // RL17
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Effective address and operand checks

	wire logic [31:0] ea;
	wire logic idx_bad;
	wire logic imm_bad;
	wire logic [31:0] ip_seq;

	oaa_ea_calc u_ea (
		.ad32(ad32),
		.base_en(dec.base_en),
		.base_val(dec.base_val),
		.idx_en(dec.idx_en),
		.idx_idx(dec.idx_idx),
		.idx_val(dec.idx_val),
		.scale(dec.scale),
		.disp_sz(dec.disp_sz),
		.disp(dec.disp),
		.ea(ea),
		.idx_bad(idx_bad)
	);

	// Immediate destination, divide by immediate, or an immediate past 2^32-1
	assign imm_bad = dec.dst_imm || (dec.src_imm && dec.is_div)
		|| (dec.src_imm && dec.imm[32]); // RL12 RL13

	// Instruction length is never above 15, so the add cannot reach bit 31 early
	assign ip_seq = ip_r + {28'h000_0000, dec.ilen}; // RL1

	always_comb begin
		res_nxt = res_r;
		res_nxt.valid = dec.valid;
		res_nxt.push_en = 1'b0;
		if (dec.valid) begin
			res_nxt.op32 = op32;
			res_nxt.ad32 = ad32;
			res_nxt.op_width = dec.byte_op ? 6'h08 : (op32 ? 6'h20 : 6'h10); // RL7
			res_nxt.seg = seg_sel;
			res_nxt.ea = ea; // RL8 RL9
			res_nxt.fault = idx_bad || imm_bad; // RL23 RL12 RL13
			res_nxt.push_en = (dec.flow == FLOW_CALL); // RL3
			res_nxt.push_val = mask_size(op32, ip_seq); // RL3
			res_nxt.far_off = dec.far_ptr[31:0]; // RL20
			res_nxt.far_sel = dec.far_ptr[47:32]; // RL19 RL20
			res_nxt.quad_hi = dec.quad[63:32]; // RL14
			res_nxt.quad_lo = dec.quad[31:0]; // RL14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next instruction offset

	// Only decoded control flow moves it; fetch-side prefetch has no input here
	always_comb begin // RL4
		ip_nxt = ip_r;
		if (dec.valid) begin
			case (dec.flow)
				FLOW_SEQ: ip_nxt = ip_seq; // RL1
				FLOW_BRANCH: ip_nxt = dec.target; // RL1
				FLOW_CALL: ip_nxt = dec.target; // RL1
				FLOW_INT: ip_nxt = dec.target; // RL1
				FLOW_RET: ip_nxt = ret_ptr; // RL3
				FLOW_INTERRUPT_RETURN_INSTR: ip_nxt = ret_ptr; // RL3
				default: ip_nxt = ip_r;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ip_r <= `OAA_IP_RST;
			res_r <= '0;
		end else begin
			ip_r <= ip_nxt;
			res_r <= res_nxt;
		end
	end

	assign res = res_r;
	assign next_instr_offset = ip_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	seq_advance_a: assert property ( // RL1
		dec.valid && dec.flow == FLOW_SEQ |=>
		ip_r == $past(ip_r) + {28'h000_0000, $past(dec.ilen)})
		else $error("offset did not advance by length");

	ip_hold_a: assert property (!dec.valid |=> $stable(ip_r)) // RL2
		else $error("offset moved without an instruction");

	call_push_a: assert property ( // RL3
		dec.valid && dec.flow == FLOW_CALL && def32 && !dec.pfx_op |=>
		res.push_en && res.push_val == $past(ip_seq) && ip_r == $past(dec.target))
		else $error("call push value wrong");

	ret_load_a: assert property ( // RL3
		dec.valid && (dec.flow == FLOW_RET || dec.flow == FLOW_INTERRUPT_RETURN_INSTR) |=>
		ip_r == $past(ret_ptr) && !res.push_en)
		else $error("return did not reload offset");

	real_size_a: assert property ( // RL6
		dec.valid && !prot && !dec.pfx_op && !dec.pfx_ad |=> !res.op32 && !res.ad32)
		else $error("16-bit default not forced");

	prot_size_a: assert property ( // RL11
		dec.valid && prot |=>
		res.op32 == ($past(ctrl_r[`OAA_CTRL_DFLAG]) ^ $past(dec.pfx_op))
		&& res.ad32 == ($past(ctrl_r[`OAA_CTRL_DFLAG]) ^ $past(dec.pfx_ad)))
		else $error("protected size toggle wrong");

	fixed_seg_a: assert property ( // RL18
		dec.valid && dec.seg_ovr && dec.ref_kind != REF_DATA |=>
		res.seg == ($past(dec.ref_kind) == REF_FETCH ? SEG_CS
		: $past(dec.ref_kind) == REF_STACK ? SEG_SS : SEG_ES))
		else $error("override reached a fixed segment");

	stack_seg_a: assert property ( // RL15
		dec.valid && dec.ref_kind == REF_DATA && !dec.seg_ovr && stack_base |=>
		res.seg == SEG_SS)
		else $error("stack base not in stack segment");

	idx_sp_a: assert property ( // RL23
		dec.valid && dec.idx_en && dec.idx_idx == `OAA_REG_SP |=> res.fault)
		else $error("stack pointer index not refused");

	ea_wrap_a: assert property (res.valid && !res.ad32 |-> res.ea[31:16] == 16'h0000) // RL25
		else $error("16-bit address not wrapped");

	imm_dst_a: assert property (dec.valid && dec.dst_imm |=> res.fault) // RL12
		else $error("immediate destination accepted");

	////////////////////////////////////////////////////////////////////////
	// Checks on widths, segments, operands and transfers

	op_width_a: assert property ( // RL7
		dec.valid |=> res.op_width == ($past(dec.byte_op) ? 6'h08
		: (res.op32 ? 6'h20 : 6'h10)))
		else $error("operand width not 8, 16 or 32");
	push_half_a: assert property ( // RL3
		dec.valid && dec.flow == FLOW_CALL && !op32 |=> res.push_val[31:16] == 16'h0000)
		else $error("16-bit return pointer not truncated");
	branch_load_a: assert property ( // RL1
		dec.valid && (dec.flow == FLOW_BRANCH || dec.flow == FLOW_INT) |=>
		ip_r == $past(dec.target) && !res.push_en)
		else $error("branch did not load the target");
	no_result_a: assert property (!dec.valid |=> !res.valid && !res.push_en) // RL3
		else $error("result or push without an instruction");
	fetch_seg_a: assert property ( // RL16
		dec.valid && dec.ref_kind == REF_FETCH |=> res.seg == SEG_CS)
		else $error("fetch outside the code segment");
	push_seg_a: assert property ( // RL15
		dec.valid && dec.ref_kind == REF_STACK |=> res.seg == SEG_SS)
		else $error("push or pop outside the stack segment");
	strdst_seg_a: assert property ( // RL16
		dec.valid && dec.ref_kind == REF_STRDST |=> res.seg == SEG_ES)
		else $error("string destination outside extra segment");
	data_seg_a: assert property ( // RL16
		dec.valid && dec.ref_kind == REF_DATA && !dec.seg_ovr && !stack_base |=>
		res.seg == SEG_DS)
		else $error("plain data reference outside data segment");
	ovr_seg_a: assert property ( // RL17
		dec.valid && dec.ref_kind == REF_DATA && dec.seg_ovr |=>
		res.seg == $past(dec.ovr_seg))
		else $error("override segment not applied");
	div_imm_a: assert property (dec.valid && dec.src_imm && dec.is_div |=> res.fault) // RL13
		else $error("divide by immediate accepted");
	imm_wide_a: assert property (dec.valid && dec.src_imm && dec.imm[32] |=> res.fault) // RL13
		else $error("immediate above doubleword accepted");
	quad_pair_a: assert property ( // RL14
		dec.valid |=> res.quad_hi == $past(dec.quad[63:32])
		&& res.quad_lo == $past(dec.quad[31:0]))
		else $error("quadword halves swapped");
	far_split_a: assert property ( // RL20
		dec.valid |=> res.far_off == $past(dec.far_ptr[31:0])
		&& res.far_sel == $past(dec.far_ptr[47:32]))
		else $error("far pointer split wrong");
	clean_fault_a: assert property ( // RL23
		dec.valid && !dec.dst_imm && !dec.src_imm && !dec.idx_en |=> !res.fault)
		else $error("fault raised on a legal instruction");

	call_c: cover property (dec.valid && dec.flow == FLOW_CALL ##1 dec.valid
		&& dec.flow == FLOW_RET);
	ovr_c: cover property (dec.valid && dec.seg_ovr && dec.ref_kind == REF_DATA);
	scaled_c: cover property (dec.valid && dec.idx_en && dec.scale == 2'h3 && dec.base_en);
	prot32_c: cover property (dec.valid && def32 && dec.pfx_ad);

endmodule : oaa_unit

/* File: oaa_defines.svh */
// Constants for the operand and address attribute unit
`ifndef OAA_DEFINES_SVH
`define OAA_DEFINES_SVH

`define OAA_CTRL_OFS 8'h00
`define OAA_STAT_OFS 8'h04
`define OAA_EA_OFS 8'h08
`define OAA_CTRL_RST 32'h0000_0000
`define OAA_CTRL_PROT 0
`define OAA_CTRL_V86 1
`define OAA_CTRL_SMM 2
`define OAA_CTRL_DFLAG 3
`define OAA_STAT_OP32 0
`define OAA_STAT_AD32 1
`define OAA_STAT_FAULT 2
`define OAA_STAT_SEG_LO 4
`define OAA_REG_SP 3'h4
`define OAA_REG_BP 3'h5
`define OAA_DISP_NONE 2'h0
`define OAA_DISP_8 2'h1
`define OAA_DISP_16 2'h2
`define OAA_DISP_32 2'h3
`define OAA_MASK16 32'h0000_FFFF
`define OAA_IP_RST 32'h0000_0000
`define OAA_HTRANS_NONSEQ 2'h2
`define OAA_HSIZE_WORD 3'h2

`endif

/* File: oaa_pkg.sv */
// Types shared by the operand and address attribute unit
package oaa_pkg;

	typedef enum logic [2:0] {SEG_ES, SEG_CS, SEG_SS, SEG_DS, SEG_FS, SEG_GS} oaa_seg_t;
	typedef enum logic [1:0] {REF_FETCH, REF_STACK, REF_STRDST, REF_DATA} oaa_ref_t;
	typedef enum logic [2:0] {FLOW_SEQ, FLOW_BRANCH, FLOW_CALL, FLOW_RET, FLOW_INTERRUPT_RETURN_INSTR, FLOW_INT}
		oaa_flow_t;

	typedef struct packed {
		logic valid;
		logic [3:0] ilen;
		logic pfx_op;
		logic pfx_ad;
		logic seg_ovr;
		oaa_seg_t ovr_seg;
		oaa_ref_t ref_kind;
		logic base_en;
		logic [2:0] base_idx;
		logic [31:0] base_val;
		logic idx_en;
		logic [2:0] idx_idx;
		logic [31:0] idx_val;
		logic [1:0] scale;
		logic [1:0] disp_sz;
		logic [31:0] disp;
		oaa_flow_t flow;
		logic [31:0] target;
		logic byte_op;
		logic src_imm;
		logic dst_imm;
		logic is_div;
		logic [32:0] imm;
		logic [47:0] far_ptr;
		logic [63:0] quad;
	} oaa_dec_t;

	typedef struct packed {
		logic valid;
		logic op32;
		logic ad32;
		logic [5:0] op_width;
		oaa_seg_t seg;
		logic [31:0] ea;
		logic push_en;
		logic [31:0] push_val;
		logic fault;
		logic [31:0] far_off;
		logic [15:0] far_sel;
		logic [31:0] quad_hi;
		logic [31:0] quad_lo;
	} oaa_res_t;

endpackage : oaa_pkg

/* File: oaa_ea_calc.sv */
// Effective address adder: displacement + base + scaled index
`include "oaa_defines.svh"
module oaa_ea_calc
	import oaa_pkg::*;
(
	input wire logic ad32,
	input wire logic base_en,
	input wire logic [31:0] base_val,
	input wire logic idx_en,
	input wire logic [2:0] idx_idx,
	input wire logic [31:0] idx_val,
	input wire logic [1:0] scale,
	input wire logic [1:0] disp_sz,
	input wire logic [31:0] disp,
	output logic [31:0] ea,
	output logic idx_bad
);

	function automatic logic [31:0] disp_ext(input logic [1:0] sz, input logic [31:0] d);
		case (sz)
			`OAA_DISP_8: disp_ext = {{24{d[7]}}, d[7:0]};
			`OAA_DISP_16: disp_ext = {{16{d[15]}}, d[15:0]};
			`OAA_DISP_32: disp_ext = d;
			default: disp_ext = 32'h0000_0000;
		endcase
	endfunction : disp_ext

	wire logic [31:0] base_term;
	wire logic [31:0] idx_term;
	wire logic [31:0] disp_term;
	wire logic [31:0] sum;

	// Stack pointer can never index; such an index is dropped and flagged
	assign idx_bad = idx_en && (idx_idx == `OAA_REG_SP); // RL23
	assign base_term = base_en ? base_val : 32'h0000_0000; // RL24
	// Scale only on a real index; scale is an unsigned shift
	assign idx_term = (idx_en && !idx_bad) ? (idx_val << scale) : 32'h0000_0000; // RL24 RL22
	// Short displacement follows the 16-bit address width
	assign disp_term = disp_ext((!ad32 && disp_sz == `OAA_DISP_32) ? `OAA_DISP_16 : disp_sz,
		disp); // RL8 RL9 RL21
	// Two's complement sum wraps naturally at 32 bits
	assign sum = base_term + idx_term + disp_term; // RL21 RL22
	assign ea = ad32 ? sum : (sum & `OAA_MASK16); // RL25

endmodule : oaa_ea_calc

/* File: oaa_stack_model.sv */
// Far-side stack model: keeps the last pushed return pointer
module oaa_stack_model
	import oaa_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire oaa_res_t res,
	output logic [31:0] ret_ptr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] top_r;
	// One entry only; nested returns would need a deeper stack
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			top_r <= 32'h0;
		end else if (res.valid && res.push_en) begin
			top_r <= res.push_val;
		end
	end
	assign ret_ptr = top_r;
endmodule : oaa_stack_model

/* File: test_oaa_unit.sv */
// Self-checking bench for the operand and address attribute unit
`include "oaa_defines.svh"
module test_oaa_unit
	import oaa_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, def32;
	logic [1:0] htrans;
	logic [2:0] hsize, sx;
	logic [31:0] haddr, hwdata, hrdata, ret_ptr, nio, rd, pv;
	oaa_dec_t dec, d;
	oaa_res_t res;
	int mismatches, compares, cyc;
	oaa_flow_t fl[8] = '{FLOW_BRANCH, FLOW_SEQ, FLOW_CALL, FLOW_SEQ, FLOW_RET, FLOW_CALL,
		FLOW_INTERRUPT_RETURN_INSTR, FLOW_INT};
	logic [3:0] il[8] = '{4'h2, 4'h3, 4'h5, 4'h4, 4'h1, 4'h1, 4'h1, 4'h1};
	logic [31:0] tg[8] = '{32'h1000, 32'h0, 32'h2000, 32'h0, 32'h0, 32'h3000, 32'h0, 32'h4000};
	logic [31:0] ni[8] = '{32'h1000, 32'h1003, 32'h2000, 32'h2004, 32'h1008, 32'h3000,
		32'h1009, 32'h4000};

	oaa_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dec(dec), .ret_ptr(ret_ptr), .res(res),
		.next_instr_offset(nio));
	oaa_stack_model far (.hclk(hclk), .hresetn(hresetn), .res(res), .ret_ptr(ret_ptr));

	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (mismatches == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	// Waits on hready rather than a fixed count; the timeout cuts a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= `OAA_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", hresp, 1'b0);
		chk("hready", hreadyout, 1'b1);
	endtask : bus

	task automatic issue(input oaa_dec_t x);
		x.valid = 1'b1;
		@(posedge hclk);
		dec <= x;
		@(posedge hclk);
		dec.valid <= 1'b0;
		#1;
		chk("res_valid", res.valid, 1'b1);
	endtask : issue

	task automatic ea(input logic pad, ie, input logic [2:0] ii, input logic [1:0] sc, ds,
		input logic [31:0] bv, iv, dv, ex);
		d = '0;
		d.ref_kind = REF_DATA;
		d.pfx_ad = pad;
		d.base_en = 1'b1;
		d.base_idx = 3'h3;
		d.base_val = bv;
		d.idx_en = ie;
		d.idx_idx = ii;
		d.idx_val = iv;
		d.scale = sc;
		d.disp_sz = ds;
		d.disp = dv;
		issue(d);
		chk("ea", res.ea, ex);
		chk("ea_fault", res.fault, ie && ii == `OAA_REG_SP);
	endtask : ea

	////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc > 3000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = `OAA_HSIZE_WORD;
		hwdata = 32'h0;
		dec = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk("nio_rst", nio, `OAA_IP_RST);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl_rst", rd, `OAA_CTRL_RST);
		bus(1'b1, 8'h00, 32'hFFFF_FFFF);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl_rw", rd, 32'h0000_000F);
		bus(1'b0, 8'h0C, 32'h0);
		chk("unmapped", rd, 32'h0);
		for (int m = 0; m < 16; m++) begin
			bus(1'b1, 8'h00, {28'h0, m[3:0]});
			def32 = m[0] & !m[1] & !m[2] & m[3];
			for (int p = 0; p < 4; p++) begin
				d = '0;
				d.ilen = 4'h1;
				d.pfx_op = p[0];
				d.pfx_ad = p[1];
				d.byte_op = (p == 3);
				issue(d);
				chk("op32", res.op32, def32 ^ p[0]);
				chk("ad32", res.ad32, def32 ^ p[1]);
				chk("opw", res.op_width, p == 3 ? 6'h08 : (def32 ^ p[0]) ? 6'h20 : 6'h10);
			end
			bus(1'b0, 8'h04, 32'h0);
			chk("stat", rd[1:0], {2{~def32}});
		end
		for (int r = 0; r < 4; r++) begin
			for (int b = 0; b < 3; b++) begin
				for (int o = 0; o < 2; o++) begin
					d = '0;
					d.ref_kind = oaa_ref_t'(r);
					d.base_en = 1'b1;
					d.base_idx = b == 0 ? 3'h3 : b == 1 ? `OAA_REG_SP : `OAA_REG_BP;
					d.seg_ovr = o[0];
					d.ovr_seg = SEG_FS;
					sx = r == 0 ? SEG_CS : r == 1 ? SEG_SS : r == 2 ? SEG_ES : o == 1 ? SEG_FS :
						b != 0 ? SEG_SS : SEG_DS;
					issue(d);
					chk("seg", res.seg, sx);
				end
			end
		end
		bus(1'b1, 8'h00, 32'h9);
		ea(1'b0, 1'b1, 3'h1, 2'h3, `OAA_DISP_8, 32'h10, 32'hFFFF_FFFF, 32'hF0, 32'hFFFF_FFF8);
		ea(1'b1, 1'b1, 3'h1, 2'h3, `OAA_DISP_8, 32'h10, 32'hFFFF_FFFF, 32'hF0, 32'hFFF8);
		ea(1'b0, 1'b0, 3'h1, 2'h3, `OAA_DISP_NONE, 32'h10, 32'h5, 32'h0, 32'h10);
		ea(1'b0, 1'b1, `OAA_REG_SP, 2'h0, `OAA_DISP_NONE, 32'h10, 32'h100, 32'h0, 32'h10);
		ea(1'b1, 1'b0, 3'h1, 2'h0, `OAA_DISP_16, 32'h1_7000, 32'h0, 32'h8000, 32'hF000);
		ea(1'b0, 1'b1, 3'h2, 2'h2, `OAA_DISP_32, 32'h0, 32'h2, 32'h1234_5678, 32'h1234_5680);
		pv = nio;
		bus(1'b1, 8'h08, 32'hFFFF_FFFF);
		bus(1'b0, 8'h08, 32'h0);
		chk("ea_reg", rd, 32'h1234_5680);
		chk("nio_sw", nio, pv);
		for (int k = 0; k < 8; k++) begin
			d = '0;
			d.flow = fl[k];
			d.ilen = il[k];
			d.target = tg[k];
			pv = ni[(k + 7) % 8] + {28'h0, il[k]};
			issue(d);
			chk("nio", nio, ni[k]);
			chk("push_en", res.push_en, fl[k] == FLOW_CALL);
			if (fl[k] == FLOW_CALL) chk("push_val", res.push_val, pv);
		end
		// Return pointer above 64K must be cut when the call runs at 16-bit size
		d = '0;
		d.target = 32'h0001_2340;
		d.flow = FLOW_BRANCH;
		issue(d);
		d.flow = FLOW_CALL;
		d.pfx_op = 1'b1;
		d.ilen = 4'h2;
		d.target = 32'h0000_5000;
		issue(d);
		chk("push16", res.push_val, 32'h0000_2342);
		chk("nio_call", nio, 32'h0000_5000);
		for (int k = 0; k < 5; k++) begin
			d = '0;
			d.src_imm = (k != 1);
			d.dst_imm = (k == 1);
			d.is_div = (k == 2);
			d.imm = k == 3 ? 33'h1_0000_0000 : 33'h0_FFFF_FFFF;
			d.quad = 64'h1122_3344_5566_7788 + k;
			d.far_ptr = {16'hABC0 + k[15:0], 32'h0123_4567};
			issue(d);
			chk("fault", res.fault, k >= 1 && k <= 3);
			chk("quad_hi", res.quad_hi, 32'h1122_3344);
			chk("quad_lo", res.quad_lo, 32'h5566_7788 + k);
			chk("far_off", res.far_off, 32'h0123_4567);
			chk("far_sel", res.far_sel, 16'hABC0 + k[15:0]);
		end
		print_verdict();
	end
endmodule : test_oaa_unit
